// File: pkg/gpio_port_defines.svh
// Constants of the 32-line programmable I/O port: register map, reset images, strap lines.
// Assumes a 32-bit APB with an 8-bit byte address; each register takes one aligned word.
`ifndef GPIO_PORT_DEFINES_SVH
`define GPIO_PORT_DEFINES_SVH

// Number of lines and width of one line group.
`define LINE_COUNT 32
`define GROUP_WIDTH 16
`define ADDR_WIDTH 8

// Byte addresses of the registers; low words hold lines 0-15, high words lines 16-31.
`define ADDR_MODE_LO 8'h00
`define ADDR_MODE_HI 8'h04
`define ADDR_DIR_LO 8'h08
`define ADDR_DIR_HI 8'h0c
`define ADDR_OUT_LO 8'h10
`define ADDR_OUT_HI 8'h14
`define ADDR_PIN_LO 8'h18
`define ADDR_PIN_HI 8'h1c
`define ADDR_ODRAIN_LO 8'h20
`define ADDR_ODRAIN_HI 8'h24
`define ADDR_STRAP 8'h28

// Reset images: every line is mode 0; direction 1 except lines 4-9, which keep the shared use.
`define RST_MODE 32'h00000000
`define RST_DIR 32'hfffffc0f
`define RST_OUT 32'h00000000
`define RST_ODRAIN 32'h00000000

// Lines whose weak pull is fixed as pull-down; every other line pulls up.
`define PULL_DOWN_LINES 32'h00c00402

// Lines sampled after reset to pick the clock multiplier.
`define STRAP_A_LINE 29
`define STRAP_B_LINE 26

`endif

// File: pkg/gpio_port_pkg.sv
// Types of the 32-line programmable I/O port.
// Assumes the constants header sits beside it on the include path.
`include "gpio_port_defines.svh"

package gpio_port_pkg;

	// Line-wide vector type.
	typedef logic [`LINE_COUNT-1:0] line_vec_type;

	// Complete state of the port, registered as one word.
	typedef struct packed {
		line_vec_type mode;
		line_vec_type dir;
		line_vec_type outLevel;
		line_vec_type openDrain;
		line_vec_type pinOut;
		line_vec_type pinOe;
		line_vec_type pullUpEn;
		line_vec_type pullDownEn;
		line_vec_type periphIn;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic strapA;
		logic strapB;
		logic strapValid;
	} state_type;

endpackage

// File: design/pin_input_sync.sv
// Two-stage synchroniser for a vector of asynchronous pin levels.
// Assumes each bit is an independent level; no reset, the chain settles in two edges.
`timescale 1ns/1ps

module pin_input_sync #(
	parameter int WIDTH = `LINE_COUNT
) (
	input wire logic mclk,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	// Elaboration check on the width.
	if (WIDTH < 1) begin : g_bad_width
		$error("pin_input_sync needs at least one bit");
	end

	// One chain per bit; the first stage feeds only the second.
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic meta_ff; // First stage, may be metastable.
		logic sync_ff; // Second stage, safe to use.
		always_ff @(posedge mclk) begin
			meta_ff <= asyncIn[i];
			sync_ff <= meta_ff;
		end
		assign syncOut[i] = sync_ff;
	end

endmodule // pin_input_sync

// File: design/programmable_io_line_port.sv
// Programmable I/O line port: 32 pins, each shared, input or output, with APB registers.
// Assumes pins arrive asynchronously; the shared peripheral runs on mclk.
//
// Contract
// - Thirty-two lines, each usable as software I/O.
// - Mode and direction bit pair choose function.
// - Pull polarity fixed per line, only presence selectable.
// - A line can be an open-drain output.
// - Reset gives fixed per-line defaults.
// - Pin read returns one 16-line group.
// - Written level drives pin only in output.
// - Lines 26 and 29 sampled at reset.
// - Mode and direction held in 16-bit registers.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps

module programmable_io_line_port
	import gpio_port_pkg::line_vec_type;
#(
	parameter int LINES = `LINE_COUNT
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire gpio_port_pkg::line_vec_type pinIn,
	output gpio_port_pkg::line_vec_type pinOut,
	output gpio_port_pkg::line_vec_type pinOe,
	output gpio_port_pkg::line_vec_type pullUpEn,
	output gpio_port_pkg::line_vec_type pullDownEn,
	input wire gpio_port_pkg::line_vec_type periphOut,
	input wire gpio_port_pkg::line_vec_type periphOe,
	output gpio_port_pkg::line_vec_type periphIn,
	output logic clockMultiplierStrapA,
	output logic clockMultiplierStrapB,
	output logic strapValid
);
	import gpio_port_pkg::*;

	// The group split, strap lines and reset images are built for exactly 32 lines.
	if (LINES != `LINE_COUNT) begin : g_bad_lines
		$error("programmable_io_line_port serves exactly 32 lines");
	end

	// Image of the whole state under reset.
	localparam state_type ST_RESET = '{
		mode: `RST_MODE,
		dir: `RST_DIR,
		outLevel: `RST_OUT,
		openDrain: `RST_ODRAIN,
		pinOut: '0,
		pinOe: '0,
		pullUpEn: `RST_DIR & ~`PULL_DOWN_LINES,
		pullDownEn: `RST_DIR & `PULL_DOWN_LINES,
		periphIn: '0,
		prdata: '0,
		pready: 1'b0,
		pslverr: 1'b0,
		strapA: 1'b0,
		strapB: 1'b0,
		strapValid: 1'b0
	};

	// Group width as an integer constant for slicing the line vectors into groups.
	localparam int GW = `GROUP_WIDTH;

	state_type st_ff; // Registered state.
	state_type nxt_st; // Next state from the combinational process.
	line_vec_type syncPin; // Pin levels after two flip-flops.
	line_vec_type sharedMask; // Lines left to the shared function.
	line_vec_type inputMask; // Lines in either input mode.
	line_vec_type pullMask; // Lines in input mode with the weak pull.
	line_vec_type pushMask; // Lines driven push-pull.
	line_vec_type drainMask; // Lines driven open-drain.
	line_vec_type pinRead; // Input levels masked to input lines.
	logic [31:0] readWord; // Word returned by the addressed register.
	logic addrHit; // The address names a register.
	logic addrReadOnly; // The address names a read-only register.
	logic accessNow; // Access phase waiting for the answer.
	logic doWrite; // A write completes at this edge.

	// Pins come from the board and pass two flip-flops before use.
	pin_input_sync #(
		.WIDTH(LINES)
	) u_pin_sync (
		.mclk(mclk),
		.asyncIn(pinIn),
		.syncOut(syncPin)
	);

	// Decode of each line's function and the next state of the whole port.
	always_comb begin
		nxt_st = st_ff;
		// Mode 0 dir 0 shared, dir 1 selects input, mode 1 dir 0 output.
		sharedMask = ~st_ff.mode & ~st_ff.dir;
		inputMask = st_ff.dir;
		pullMask = ~st_ff.mode & st_ff.dir;
		pushMask = st_ff.mode & ~st_ff.dir & ~st_ff.openDrain;
		drainMask = st_ff.mode & ~st_ff.dir & st_ff.openDrain;
		pinRead = syncPin & inputMask;

		// Shared lines follow the peripheral; push-pull output lines carry the written level.
		nxt_st.pinOut = (periphOut & sharedMask) | (st_ff.outLevel & pushMask);
		// An open-drain line only ever pulls low, and only when the level is 0.
		nxt_st.pinOe = (periphOe & sharedMask) | pushMask
			| (drainMask & ~st_ff.outLevel);
		// Software turns the pull on or off; its polarity is fixed per line.
		nxt_st.pullUpEn = pullMask & ~`PULL_DOWN_LINES;
		nxt_st.pullDownEn = pullMask & `PULL_DOWN_LINES;
		// The shared peripheral always sees the pin level.
		nxt_st.periphIn = syncPin;

		// Capture the straps once, on the first edge after reset release.
		if (!st_ff.strapValid) begin
			nxt_st.strapA = syncPin[`STRAP_A_LINE];
			nxt_st.strapB = syncPin[`STRAP_B_LINE];
			nxt_st.strapValid = 1'b1;
		end

		// Register read decode; bit n of a group word is line n of the group.
		addrHit = 1'b1;
		addrReadOnly = 1'b0;
		case (paddr)
			`ADDR_MODE_LO: begin
				readWord = {16'h0000, st_ff.mode[GW-1:0]};
			end
			`ADDR_MODE_HI: begin
				readWord = {16'h0000, st_ff.mode[LINES-1:GW]};
			end
			`ADDR_DIR_LO: begin
				readWord = {16'h0000, st_ff.dir[GW-1:0]};
			end
			`ADDR_DIR_HI: begin
				readWord = {16'h0000, st_ff.dir[LINES-1:GW]};
			end
			`ADDR_OUT_LO: begin
				readWord = {16'h0000, st_ff.outLevel[GW-1:0]};
			end
			`ADDR_OUT_HI: begin
				readWord = {16'h0000, st_ff.outLevel[LINES-1:GW]};
			end
			`ADDR_PIN_LO: begin
				readWord = {16'h0000, pinRead[GW-1:0]};
				addrReadOnly = 1'b1;
			end
			`ADDR_PIN_HI: begin
				readWord = {16'h0000, pinRead[LINES-1:GW]};
				addrReadOnly = 1'b1;
			end
			`ADDR_ODRAIN_LO: begin
				readWord = {16'h0000, st_ff.openDrain[GW-1:0]};
			end
			`ADDR_ODRAIN_HI: begin
				readWord = {16'h0000, st_ff.openDrain[LINES-1:GW]};
			end
			`ADDR_STRAP: begin
				readWord = {29'h0, st_ff.strapValid, st_ff.strapB, st_ff.strapA};
				addrReadOnly = 1'b1;
			end
			default: begin
				// Unmapped addresses read zero and answer with an error.
				readWord = 32'h0000_0000;
				addrHit = 1'b0;
			end
		endcase

		// One wait state: ready rises in the first access cycle, done in the second.
		accessNow = psel && penable && !st_ff.pready;
		doWrite = psel && penable && st_ff.pready && pwrite && addrHit && !addrReadOnly;
		nxt_st.pready = accessNow;
		nxt_st.pslverr = accessNow && (!addrHit || (pwrite && addrReadOnly));
		if (accessNow && !pwrite) begin
			nxt_st.prdata = readWord;
		end else if (!accessNow) begin
			nxt_st.prdata = 32'h0000_0000;
		end

		// Writes land only at the completing edge; the upper data half is ignored.
		if (doWrite) begin
			case (paddr)
				`ADDR_MODE_LO: begin
					nxt_st.mode[GW-1:0] = pwdata[GW-1:0];
				end
				`ADDR_MODE_HI: begin
					nxt_st.mode[LINES-1:GW] = pwdata[GW-1:0];
				end
				`ADDR_DIR_LO: begin
					nxt_st.dir[GW-1:0] = pwdata[GW-1:0];
				end
				`ADDR_DIR_HI: begin
					nxt_st.dir[LINES-1:GW] = pwdata[GW-1:0];
				end
				`ADDR_OUT_LO: begin
					nxt_st.outLevel[GW-1:0] = pwdata[GW-1:0];
				end
				`ADDR_OUT_HI: begin
					nxt_st.outLevel[LINES-1:GW] = pwdata[GW-1:0];
				end
				`ADDR_ODRAIN_LO: begin
					nxt_st.openDrain[GW-1:0] = pwdata[GW-1:0];
				end
				`ADDR_ODRAIN_HI: begin
					nxt_st.openDrain[LINES-1:GW] = pwdata[GW-1:0];
				end
				default: begin
					// Read-only and unmapped addresses store nothing.
					nxt_st.mode = nxt_st.mode;
				end
			endcase
		end
	end

	// State register with synchronous reset to the per-line defaults.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_ff <= ST_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Every output comes straight from the state register.
	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign pinOut = st_ff.pinOut;
	assign pinOe = st_ff.pinOe;
	assign pullUpEn = st_ff.pullUpEn;
	assign pullDownEn = st_ff.pullDownEn;
	assign periphIn = st_ff.periphIn;
	assign clockMultiplierStrapA = st_ff.strapA;
	assign clockMultiplierStrapB = st_ff.strapB;
	assign strapValid = st_ff.strapValid;

	// Checks on the port's own behaviour, all in the mclk domain.
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// Push-pull output lines drive exactly the written level one edge later.
	a_push_drive_level: assert property (
		1'b1 |=> ((pinOe & $past(pushMask)) == $past(pushMask))
			&& ((pinOut & $past(pushMask)) == $past(st_ff.outLevel & pushMask)))
		else $error("push-pull line does not drive the written level");

	// Input lines never drive the pin.
	a_input_no_drive: assert property (
		1'b1 |=> (pinOe & $past(inputMask)) == '0)
		else $error("input line is driven");

	// Open-drain lines drive only low and only for a written zero.
	a_open_drain_low: assert property (
		1'b1 |=> ((pinOut & $past(drainMask)) == '0)
			&& ((pinOe & $past(drainMask)) == $past(drainMask & ~st_ff.outLevel)))
		else $error("open-drain line drives high or at the wrong level");

	// Pull polarity never changes from its fixed per-line choice.
	a_pull_polarity: assert property (
		((pullUpEn & `PULL_DOWN_LINES) == '0) && ((pullDownEn & ~`PULL_DOWN_LINES) == '0))
		else $error("weak pull has the wrong polarity");

	// A pull is present only in mode 0 with direction 1.
	a_pull_presence: assert property (
		1'b1 |=> (pullUpEn | pullDownEn) == $past(~st_ff.mode & st_ff.dir))
		else $error("pull enable does not follow mode and direction");

	// After reset release the configuration holds the per-line defaults.
	a_reset_defaults: assert property (
		$rose(rst_n) |-> (st_ff.mode == `RST_MODE) && (st_ff.dir == `RST_DIR) && !strapValid)
		else $error("configuration after reset is not the default");

	// Straps are taken from lines 29 and 26 on the capturing edge.
	a_strap_capture: assert property (
		$rose(strapValid) |-> (clockMultiplierStrapA == $past(syncPin[`STRAP_A_LINE]))
			&& (clockMultiplierStrapB == $past(syncPin[`STRAP_B_LINE])))
		else $error("strap not taken from its line");

	// Once taken, the straps stay put until the next reset.
	a_strap_hold: assert property (
		strapValid && $past(strapValid) |-> $stable(clockMultiplierStrapA)
			&& $stable(clockMultiplierStrapB))
		else $error("strap changed after capture");

	// The upper pin read returns lines 16-31 of input lines in bits 15-0.
	a_pin_read_group: assert property (
		(accessNow && !pwrite && (paddr == `ADDR_PIN_HI)) |=>
			pready && (prdata == {16'h0000, $past(pinRead[LINES-1:GW])}))
		else $error("upper pin read returns the wrong group");

	// A completed write to the low mode word lands in lines 0-15 only.
	a_mode_write: assert property (
		(doWrite && (paddr == `ADDR_MODE_LO)) |=>
			(st_ff.mode[GW-1:0] == $past(pwdata[GW-1:0])) && $stable(st_ff.mode[LINES-1:GW]))
		else $error("mode write did not land in the low group");

	// Every answer arrives after exactly one wait cycle and lasts one cycle.
	a_apb_answer: assert property (
		accessNow |=> pready ##1 !pready)
		else $error("apb answer timing wrong");

endmodule // programmable_io_line_port

// File: test/board_pin_model.sv
// Board-side model of the 32 port pins: board drivers, weak pulls and floating lines.
// Assumes pad controls change on mclk; the bench picks which lines the board drives.
`timescale 1ns/1ps

module board_pin_model
	import gpio_port_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire gpio_port_pkg::line_vec_type pinOut,
	input wire gpio_port_pkg::line_vec_type pinOe,
	input wire gpio_port_pkg::line_vec_type pullUpEn,
	input wire gpio_port_pkg::line_vec_type pullDownEn,
	input wire gpio_port_pkg::line_vec_type extEn,
	input wire gpio_port_pkg::line_vec_type extVal,
	output gpio_port_pkg::line_vec_type pinLevel
);
	// Lines that must read high while reset is held: ready line and both straps.
	localparam line_vec_type KEEP_HIGH = 32'h24000040;
	line_vec_type lastLvl_ff; // Wire level seen at the previous edge.
	line_vec_type boardEn; // Board drive enables after the reset guard.

	// The board may drive the strap lines high during reset, never low.
	assign boardEn = rst_n ? extEn : (extEn & (extVal | ~KEEP_HIGH));

	// The port wins, then the board, then a weak pull; an undriven line toggles.
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			if (pinOe[i]) begin
				pinLevel[i] = pinOut[i];
			end else if (boardEn[i]) begin
				pinLevel[i] = extVal[i];
			end else if (pullUpEn[i] | pullDownEn[i]) begin
				pinLevel[i] = pullUpEn[i];
			end else begin
				pinLevel[i] = ~lastLvl_ff[i];
			end
		end
	end

	// Remembers the wire so a floating line never holds a stale value.
	always_ff @(posedge mclk) begin
		lastLvl_ff <= pinLevel;
	end
endmodule // board_pin_model

// File: test/tb_top.sv
// Self-checking bench of the programmable I/O line port, register access over APB.
// Assumes the constants header is on the include path and the board model beside it.
`timescale 1ns/1ps
`include "gpio_port_defines.svh"

module tb_top;
	import gpio_port_pkg::*;
	logic mclk = 1'b0; // System clock, 50 ns period.
	logic rst_n = 1'b0; // Synchronous reset, active low.
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB request.
	logic [7:0] paddr = 8'h00; // APB byte address.
	logic [31:0] pwdata = 32'h00000000, prdata; // APB data.
	logic pready, pslverr; // APB answer.
	line_vec_type pinLevel, pinOut, pinOe, pullUpEn, pullDownEn, periphIn; // Pad side.
	line_vec_type periphOut = '0, periphOe = '0; // Shared function drive.
	line_vec_type extEn = '0, extVal = '0; // Board drivers.
	logic strapA, strapB, strapOk; // Strap outputs.
	int errors = 0;
	int total_checks = 0;
	logic [31:0] rd; // Last read word.
	logic err; // Last error response.

	programmable_io_line_port i_programmable_io_line_port (.mclk(mclk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinLevel),
		.pinOut(pinOut), .pinOe(pinOe), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn),
		.periphOut(periphOut), .periphOe(periphOe), .periphIn(periphIn),
		.clockMultiplierStrapA(strapA), .clockMultiplierStrapB(strapB), .strapValid(strapOk));

	board_pin_model i_board_pin_model (.mclk(mclk), .rst_n(rst_n), .pinOut(pinOut),
		.pinOe(pinOe), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .extEn(extEn),
		.extVal(extVal), .pinLevel(pinLevel));

	// Clock generator.
	initial begin
		forever #25 mclk = ~mclk;
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Compares one value with its expectation.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; waits for pready under a bound.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Lets configuration reach the pads and the pin synchronisers refill.
	task automatic settle();
		repeat (5) @(posedge mclk);
	endtask

	// Reset images of pulls, straps and registers, with nothing driven by the board.
	task automatic reset_defaults();
		check(pullUpEn, 32'hff3ff80d);
		check(pullDownEn, `PULL_DOWN_LINES);
		check(pinOe, 32'h00000000);
		check({strapOk, strapB, strapA}, 3'h7);
		apb(1'b0, `ADDR_DIR_LO, 0);
		check(rd, 32'h0000fc0f);
		apb(1'b0, `ADDR_MODE_HI, 0);
		check(rd, 32'h00000000);
		apb(1'b0, `ADDR_PIN_LO, 0);
		check(rd, 32'h0000f80d);
		apb(1'b0, `ADDR_PIN_HI, 0);
		check(rd, 32'h0000ff3f);
	endtask

	// Line 12 as push-pull and then open-drain output; line 13 stays input.
	task automatic output_line();
		apb(1'b1, `ADDR_DIR_LO, 32'h0000ec0f);
		apb(1'b1, `ADDR_MODE_LO, 32'h5a5a1000);
		apb(1'b1, `ADDR_OUT_LO, 32'h00003000);
		settle();
		check(pinOe[13:12], 2'h1);
		check(pinOut[12], 1'b1);
		check(pullUpEn[12], 1'b0);
		apb(1'b0, `ADDR_MODE_LO, 0);
		check(rd, 32'h00001000);
		apb(1'b0, `ADDR_PIN_LO, 0);
		check(rd, 32'h0000e80d);
		apb(1'b1, `ADDR_ODRAIN_LO, 32'h00001000);
		settle();
		check(pinOe[12], 1'b0);
		apb(1'b1, `ADDR_OUT_LO, 32'h00000000);
		settle();
		check({pinOe[12], pinOut[12]}, 2'h2);
	endtask

	// Line 17 driven low by the board and switched to the pull-free mode; pull and level checked there only.
	task automatic input_line();
		extEn[17] <= 1'b1;
		extVal[17] <= 1'b0;
		apb(1'b1, `ADDR_MODE_HI, 32'h00000002);
		settle();
		check(pullUpEn[17], 1'b0);
		apb(1'b0, `ADDR_PIN_HI, 0);
		check(rd, 32'h0000ff3d);
	endtask

	// Shared function on line 5, then refused accesses.
	task automatic shared_and_errors();
		periphOut[5] <= 1'b1;
		periphOe[5] <= 1'b1;
		settle();
		check({pinOe[5], pinOut[5], periphIn[5]}, 3'h7);
		apb(1'b0, 8'h30, 0);
		check({err, rd}, 33'h100000000);
		apb(1'b1, `ADDR_PIN_LO, 32'h0000ffff);
		check(err, 1'b1);
	endtask

	// Main sequence: reset, scenarios, verdict.
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (6) @(posedge mclk);
		reset_defaults();
		output_line();
		input_line();
		shared_and_errors();
		final_report();
	end
endmodule // tb_top
